// file: fps_pkg.sv
package fps_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses, plain register port)
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_KEY0      = 16'h3010; // unlock_key_0
	localparam logic [15:0] OFS_KEY1      = 16'h3011; // unlock_key_1
	localparam logic [15:0] OFS_KEY2      = 16'h3012; // unlock_key_2
	localparam logic [15:0] OFS_KEY3      = 16'h3013; // unlock_key_3
	localparam logic [15:0] OFS_ADDR      = 16'h3014; // program_erase_address
	localparam logic [15:0] OFS_DATA      = 16'h3018; // program_data_word
	localparam logic [15:0] OFS_OPCTL     = 16'h301f; // operation_control_reg
	localparam logic [15:0] OFS_ERR       = 16'h3023; // flash_error_reg
	localparam logic [15:0] OFS_ACC       = 16'h3027; // access_control_reg
	localparam logic [15:0] OFS_SOPT_RD   = 16'h302b; // smart_option_readback
	localparam logic [15:0] OFS_POPT_RD   = 16'h302f; // protection_option_readback

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_CHIP_ERS  = 0; // whole_chip_erase_enable
	localparam int BIT_SECT_ERS  = 1; // sector_erase_enable
	localparam int BIT_OPT_PGM   = 2; // option_program_enable
	localparam int BIT_NORM_PGM  = 3; // normal_program_enable
	localparam int BIT_START     = 7; // operation start
	localparam int BIT_ERR_CLR   = 0; // clear keys and control, active low
	localparam int BIT_CFG_ERR   = 7; // multi_enable_fault
	localparam int BIT_CPU_HOLD  = 7; // cpu hold in access control

	// ------------------------------------------------------------
	// reset values and constants
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_KEY       = 8'h00;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [7:0]  RST_OPCTL     = 8'h00;
	localparam logic [7:0]  RST_ERR       = 8'h01;
	localparam logic [7:0]  RST_ACC       = 8'h03;
	localparam logic [7:0]  KEY_A         = 8'h5a;
	localparam logic [7:0]  KEY_B         = 8'ha5;
	localparam logic [31:0] OPT_SMART_ADR = 32'h0000_0e38;
	localparam logic [31:0] OPT_PROT_ADR  = 32'h0000_0e3c;
	localparam logic [31:0] FLASH_TOP     = 32'h0003_ffff;
	localparam int          SECT_BITS     = 9;
	localparam int          SECT_COUNT    = 512;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int PGM_TIME_US   = 30;
	localparam int PGM_CYCLES    = PGM_TIME_US * CLK_MHZ;
	localparam int ERS_TIME_US   = 30;
	localparam int ERS_CYCLES    = ERS_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------
	// operation codes to the array
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		OP_PGM   = 2'h0,
		OP_SERS  = 2'h1,
		OP_OPGM  = 2'h2,
		OP_WHOLE_CHIP_ERASE_ENABLE  = 2'h3
	} fps_op_e;

endpackage

// file: fps_busy_timer.sv
`timescale 1ns/1ps

// down counter that times one array operation
module fps_busy_timer
#(
	parameter int CW = 16
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          load,     // one-cycle start pulse
	input  wire logic [CW-1:0] cycles,   // duration in clocks
	output logic               done      // one-cycle pulse at end
);

	logic [CW-1:0] cnt_r;       // remaining cycles
	logic [CW-1:0] cnt_nxt;
	logic          done_r;      // end pulse
	logic          done_nxt;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (load)
			cnt_nxt = cycles;
		else if (cnt_r != '0)
		begin
			cnt_nxt  = cnt_r - CW'(1);
			done_nxt = (cnt_r == {{(CW-1){1'b0}}, 1'b1});
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;

endmodule // fps_busy_timer

// file: fps_sequencer.sv
`timescale 1ns/1ps

module fps_sequencer
#(
	parameter int PGM_CYC = fps_pkg::PGM_CYCLES,  // word program duration
	parameter int ERS_CYC = fps_pkg::ERS_CYCLES   // erase duration
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] reg_addr,      // register byte address
	input  wire logic [31:0] reg_wdata,     // write data, bytes in low bits
	input  wire logic        reg_wr,        // write strobe
	input  wire logic        reg_rd,        // read strobe
	output logic      [31:0] reg_rdata,     // read data, cycle after strobe
	input  wire logic        programming_mode_pin, // tool mode when high
	input  wire logic        arr_done,      // array finished (or 0: use timer)
	output logic             cpu_hold,      // stall processor
	output logic             sys_reset_hold,// reset for all other modules
	output logic             arr_go,        // one-cycle operation pulse
	output logic      [1:0]  arr_op,        // fps_op_e operation
	output logic      [31:0] arr_addr,      // flash-relative address
	output logic      [31:0] arr_wdata,     // word to store
	output logic             arr_busy       // operation in progress
);

	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} fps_st_e;

	localparam int TW = 16;

	fps_st_e     st_r, st_nxt;             // sequencer state
	logic [7:0]  key_r [4];                // unlock_keys storage
	logic [7:0]  key_nxt [4];
	logic [2:0]  key_pos_r, key_pos_nxt;   // next expected key index
	logic        key_bad_r, key_bad_nxt;   // out-of-order key write seen
	logic [31:0] addr_r, addr_nxt;         // program_erase_address
	logic [31:0] data_r, data_nxt;         // program_data_word
	logic [7:0]  opctl_r, opctl_nxt;       // operation_control_reg
	logic        cfg_err_r, cfg_err_nxt;   // multi_enable_fault
	logic        acc_hold_r, acc_hold_nxt; // cpu hold enable
	logic [1:0]  acc_cyc_r, acc_cyc_nxt;   // read access cycles
	logic [31:0] sopt_r, sopt_nxt;         // smart option word
	logic [31:0] popt_r, popt_nxt;         // protection option word
	logic        hardlock_r, hardlock_nxt; // protection state
	logic [31:0] rdata_r, rdata_nxt;
	logic        go_r, go_nxt;
	logic [1:0]  op_r, op_nxt;
	logic        hold_r, hold_nxt;
	logic        busy_r, busy_nxt;         // registered busy level
	logic        srst_r, srst_nxt;
	logic        tload;
	logic [TW-1:0] tcyc;
	logic        tdone;
	logic        finish;
	logic [2:0]  en_cnt;
	logic        keys_ok;

	// ------------------------------------------------------------
	// operation timer
	// ------------------------------------------------------------
	fps_busy_timer #(.CW(TW)) u_timer
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (tload),
		.cycles  (tcyc),
		.done    (tdone)
	);

	assign finish = tdone | arr_done;

	// enables counted for the one-hot check
	always_comb
	begin
		en_cnt = 3'h0;
		for (int i = 0; i < 4; i++)
			en_cnt = en_cnt + {2'h0, opctl_r[i]};
	end

	// exact unlock sequence present
	assign keys_ok = !key_bad_r && key_pos_r == 3'h4
		&& key_r[0] == fps_pkg::KEY_A && key_r[1] == fps_pkg::KEY_B
		&& key_r[2] == fps_pkg::KEY_A && key_r[3] == fps_pkg::KEY_B;

	// ------------------------------------------------------------
	// register and sequencer next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt       = st_r;
		key_nxt      = key_r;
		key_pos_nxt  = key_pos_r;
		key_bad_nxt  = key_bad_r;
		addr_nxt     = addr_r;
		data_nxt     = data_r;
		opctl_nxt    = opctl_r;
		cfg_err_nxt  = cfg_err_r;
		acc_hold_nxt = acc_hold_r;
		acc_cyc_nxt  = acc_cyc_r;
		sopt_nxt     = sopt_r;
		popt_nxt     = popt_r;
		hardlock_nxt = hardlock_r;
		rdata_nxt    = 32'h0000_0000;
		go_nxt       = 1'b0;
		op_nxt       = op_r;
		tload        = 1'b0;
		tcyc         = TW'(PGM_CYC);
		srst_nxt     = programming_mode_pin;

		// register writes (control locked while running)
		if (reg_wr)
		begin
			case (reg_addr)
				fps_pkg::OFS_KEY0, fps_pkg::OFS_KEY1,
				fps_pkg::OFS_KEY2, fps_pkg::OFS_KEY3:
				begin
					// key 0 always restarts a fresh unlock, then ascending only
					if (reg_addr[1:0] == 2'h0)
					begin
						key_nxt[0]  = reg_wdata[7:0];
						key_pos_nxt = 3'h1;
						key_bad_nxt = 1'b0;
					end
					else if (reg_addr[1:0] == key_pos_r[1:0] && !key_pos_r[2])
					begin
						key_nxt[reg_addr[1:0]] = reg_wdata[7:0];
						key_pos_nxt = key_pos_r + 3'h1;
					end
					else
						key_bad_nxt = 1'b1;
				end
				fps_pkg::OFS_ADDR:
					if (st_r == ST_IDLE)
						addr_nxt = reg_wdata & fps_pkg::FLASH_TOP;
				fps_pkg::OFS_DATA:
					if (st_r == ST_IDLE)
						data_nxt = reg_wdata;
				fps_pkg::OFS_OPCTL:
					if (st_r == ST_IDLE)
						opctl_nxt = {reg_wdata[7], 3'h0, reg_wdata[3:0]};
				fps_pkg::OFS_ERR:
				begin
					if (!reg_wdata[fps_pkg::BIT_ERR_CLR])
					begin
						for (int k = 0; k < 4; k++)
							key_nxt[k] = fps_pkg::RST_KEY;
						key_pos_nxt = 3'h0;
						key_bad_nxt = 1'b0;
						opctl_nxt   = fps_pkg::RST_OPCTL;
						cfg_err_nxt = 1'b0;
					end
				end
				fps_pkg::OFS_ACC:
				begin
					acc_hold_nxt = reg_wdata[fps_pkg::BIT_CPU_HOLD];
					acc_cyc_nxt  = reg_wdata[1:0];
				end
				default: ;
			endcase
		end

		// reads: keys read zero, option words only via readback
		if (reg_rd)
		begin
			case (reg_addr)
				fps_pkg::OFS_ADDR:    rdata_nxt = addr_r;
				fps_pkg::OFS_DATA:    rdata_nxt = data_r;
				fps_pkg::OFS_OPCTL:   rdata_nxt = {24'h0, opctl_r};
				fps_pkg::OFS_ERR:     rdata_nxt = {24'h0, cfg_err_r, 7'h01};
				fps_pkg::OFS_ACC:     rdata_nxt = {24'h0, acc_hold_r, 5'h0, acc_cyc_r};
				fps_pkg::OFS_SOPT_RD: rdata_nxt = sopt_r;
				fps_pkg::OFS_POPT_RD: rdata_nxt = popt_r;
				default:              rdata_nxt = 32'h0000_0000;
			endcase
		end

		// sequencer
		case (st_r)
			ST_IDLE:
			begin
				if (opctl_r[fps_pkg::BIT_START])
				begin
					if (en_cnt > 3'h1)
					begin
						cfg_err_nxt = 1'b1;
						opctl_nxt[fps_pkg::BIT_START] = 1'b0;
					end
					else if (!keys_ok || en_cnt == 3'h0
						|| (opctl_r[fps_pkg::BIT_SECT_ERS] && programming_mode_pin))
					begin
						opctl_nxt[fps_pkg::BIT_START] = 1'b0;
						for (int k = 0; k < 4; k++)
							key_nxt[k] = fps_pkg::RST_KEY;
						key_pos_nxt = 3'h0;
					end
					else
					begin
						go_nxt = 1'b1;
						tload  = 1'b1;
						st_nxt = ST_RUN;
						if (opctl_r[fps_pkg::BIT_NORM_PGM])
						begin
							op_nxt = fps_pkg::OP_PGM;
							addr_nxt[1:0] = 2'h0;
						end
						else if (opctl_r[fps_pkg::BIT_OPT_PGM])
							op_nxt = fps_pkg::OP_OPGM;
						else if (opctl_r[fps_pkg::BIT_SECT_ERS])
						begin
							op_nxt = fps_pkg::OP_SERS;
							addr_nxt[fps_pkg::SECT_BITS-1:0] = '0;
							tcyc   = TW'(ERS_CYC);
						end
						else
						begin
							op_nxt = fps_pkg::OP_WHOLE_CHIP_ERASE_ENABLE;
							tcyc   = TW'(ERS_CYC);
						end
					end
				end
			end
			ST_RUN:
				if (finish)
					st_nxt = ST_DONE;
			ST_DONE:
			begin
				// option sector shadow updates
				if (op_r == fps_pkg::OP_OPGM && addr_r == fps_pkg::OPT_SMART_ADR)
					sopt_nxt = sopt_r & data_r;
				if (op_r == fps_pkg::OP_OPGM && addr_r == fps_pkg::OPT_PROT_ADR)
				begin
					popt_nxt     = popt_r & data_r;
					hardlock_nxt = (popt_r & data_r) != 32'hffff_ffff;
				end
				if (op_r == fps_pkg::OP_WHOLE_CHIP_ERASE_ENABLE)
				begin
					sopt_nxt     = 32'hffff_ffff;
					popt_nxt     = 32'hffff_ffff;
					hardlock_nxt = 1'b0;
				end
				for (int k = 0; k < 4; k++)
					key_nxt[k] = fps_pkg::RST_KEY;
				key_pos_nxt = 3'h0;
				opctl_nxt[fps_pkg::BIT_START] = 1'b0;
				st_nxt = ST_IDLE;
			end
			default:
				st_nxt = ST_IDLE;
		endcase

		hold_nxt = acc_hold_r && (st_nxt == ST_RUN);
		busy_nxt = (st_nxt == ST_RUN);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r       <= ST_IDLE;
			for (int k = 0; k < 4; k++)
				key_r[k] <= fps_pkg::RST_KEY;
			key_pos_r  <= 3'h0;
			key_bad_r  <= 1'b0;
			addr_r     <= fps_pkg::RST_WORD;
			data_r     <= fps_pkg::RST_WORD;
			opctl_r    <= fps_pkg::RST_OPCTL;
			cfg_err_r  <= 1'b0;
			acc_hold_r <= fps_pkg::RST_ACC[fps_pkg::BIT_CPU_HOLD];
			acc_cyc_r  <= fps_pkg::RST_ACC[1:0];
			sopt_r     <= 32'hffff_ffff;
			popt_r     <= 32'hffff_ffff;
			hardlock_r <= 1'b0;
			rdata_r    <= 32'h0000_0000;
			go_r       <= 1'b0;
			op_r       <= fps_pkg::OP_PGM;
			hold_r     <= 1'b0;
			busy_r     <= 1'b0;
			srst_r     <= 1'b0;
		end
		else
		begin
			st_r       <= st_nxt;
			key_r      <= key_nxt;
			key_pos_r  <= key_pos_nxt;
			key_bad_r  <= key_bad_nxt;
			addr_r     <= addr_nxt;
			data_r     <= data_nxt;
			opctl_r    <= opctl_nxt;
			cfg_err_r  <= cfg_err_nxt;
			acc_hold_r <= acc_hold_nxt;
			acc_cyc_r  <= acc_cyc_nxt;
			sopt_r     <= sopt_nxt;
			popt_r     <= popt_nxt;
			hardlock_r <= hardlock_nxt;
			rdata_r    <= rdata_nxt;
			go_r       <= go_nxt;
			op_r       <= op_nxt;
			hold_r     <= hold_nxt;
			busy_r     <= busy_nxt;
			srst_r     <= srst_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata      = rdata_r;
	assign cpu_hold       = hold_r;
	assign sys_reset_hold = srst_r;
	assign arr_go         = go_r;
	assign arr_op         = op_r;
	assign arr_addr       = addr_r;
	assign arr_wdata      = data_r;
	assign arr_busy       = busy_r;

endmodule // fps_sequencer

// file: fps_sequencer_props.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checker for the program/erase sequencer
// ------------------------------------------------------------
module fps_sequencer_props
#(
	parameter int PGM_CYC = 20, // word program duration
	parameter int ERS_CYC = 20  // erase duration
)
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        programming_mode_pin,
	input wire logic        cpu_hold,
	input wire logic        sys_reset_hold,
	input wire logic        arr_go,
	input wire logic [1:0]  arr_op,
	input wire logic [31:0] arr_addr,
	input wire logic [31:0] arr_wdata,
	input wire logic        arr_busy
);
	// longest legal busy stretch plus slack
	localparam int BMAX = PGM_CYC + ERS_CYC + 8;

	// cycles spent busy so far; a counter, as the bound may be long
	int busy_len;

	always_ff @(posedge clk_sys)
	begin
		if (rst || !arr_busy)
			busy_len <= 0;
		else
			busy_len <= busy_len + 1;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	AST_GO_ONE: assert property (arr_go |=> !arr_go)
		else $error("start pulse longer than one cycle");
	AST_GO_BUSY: assert property (arr_go |-> arr_busy ##1 arr_busy)
		else $error("start pulse without busy");
	AST_GO_FRESH: assert property (arr_go |-> !$past(arr_busy))
		else $error("start pulse during running operation");
	AST_BUSY_END: assert property (busy_len <= BMAX)
		else $error("operation never completes");
	AST_HOLD_BUSY: assert property (cpu_hold |-> arr_busy)
		else $error("cpu stalled with no operation");
	AST_TOOL_RST: assert property (!$past(rst) |->
		sys_reset_hold == $past(programming_mode_pin))
		else $error("module reset does not follow mode pin");
	AST_ADDR_HOLD: assert property (arr_busy && reg_wr && reg_addr == fps_pkg::OFS_ADDR
		|=> $stable(arr_addr))
		else $error("address changed while running");
	AST_OP_STEADY: assert property (arr_busy && !arr_go
		|-> $stable(arr_op) && $stable(arr_wdata))
		else $error("operation or data changed while running");
	AST_ADDR_LOAD: assert property (reg_wr && reg_addr == fps_pkg::OFS_ADDR && !arr_busy
		&& !$past(arr_busy) && !arr_go && reg_wdata <= fps_pkg::FLASH_TOP
		|=> arr_addr == $past(reg_wdata))
		else $error("address write not taken");
endmodule // fps_sequencer_props

bind fps_sequencer fps_sequencer_props #(.PGM_CYC(PGM_CYC), .ERS_CYC(ERS_CYC)) props_i
(
	.clk_sys(clk_sys),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.programming_mode_pin(programming_mode_pin),
	.cpu_hold(cpu_hold),
	.sys_reset_hold(sys_reset_hold),
	.arr_go(arr_go),
	.arr_op(arr_op),
	.arr_addr(arr_addr),
	.arr_wdata(arr_wdata),
	.arr_busy(arr_busy)
);

// file: fps_flash_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// flash array model: records each operation, may finish early
// ------------------------------------------------------------
module fps_flash_model
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        early,      // finish before the timer
	input  wire logic        arr_go,
	input  wire logic [1:0]  arr_op,
	input  wire logic [31:0] arr_addr,
	input  wire logic [31:0] arr_wdata,
	output logic             arr_done,   // early completion pulse
	output int               n_go,       // operations seen
	output logic      [1:0]  last_op,
	output logic      [31:0] last_addr,
	output logic      [31:0] last_wdata
);
	int cnt; // cycles left to early finish

	// capture one operation of any kind per start pulse
	always_ff @(posedge clk_sys)
	begin
		arr_done <= 1'b0;
		if (rst)
		begin
			n_go <= 0;
			cnt <= 0;
			last_op <= 2'h0;
			last_addr <= 32'h0;
			last_wdata <= 32'h0;
		end
		else if (arr_go)
		begin
			n_go <= n_go + 1;
			last_op <= arr_op;
			last_addr <= arr_addr;
			last_wdata <= arr_wdata;
			cnt <= early ? 8 : 0;
		end
		else if (cnt == 1)
		begin
			arr_done <= 1'b1;
			cnt <= 0;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule // fps_flash_model

// file: tb_fps_sequencer.sv
`timescale 1ns/1ps

module tb_fps_sequencer;
	localparam int CYC = 20; // shortened operation time
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] reg_addr = 16'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        programming_mode_pin = 1'b0;
	logic        early = 1'b0;
	logic        arr_done, cpu_hold, sys_reset_hold, arr_go, arr_busy, seen;
	logic [1:0]  arr_op, last_op;
	logic [31:0] reg_rdata, arr_addr, arr_wdata, last_addr, last_wdata;
	logic [31:0] rv, r, a, d;
	logic [31:0] sh [2];                          // option shadow expectation
	logic [7:0]  ctl [4] = '{8'h88, 8'h82, 8'h84, 8'h81};
	int          n_go, k, ng, n_fail = 0, n_tests = 0, cyc = 0;

	fps_sequencer #(.PGM_CYC(CYC), .ERS_CYC(CYC)) fps_sequencer_i
	(
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.programming_mode_pin(programming_mode_pin), .arr_done(arr_done),
		.cpu_hold(cpu_hold), .sys_reset_hold(sys_reset_hold), .arr_go(arr_go),
		.arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_busy(arr_busy)
	);
	fps_flash_model fps_flash_model_i
	(
		.clk_sys(clk_sys), .rst(rst), .early(early), .arr_go(arr_go), .arr_op(arr_op),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_done(arr_done), .n_go(n_go),
		.last_op(last_op), .last_addr(last_addr), .last_wdata(last_wdata)
	);

	// ------------------------------------------------------------
	// clock, timeout, helpers
	// ------------------------------------------------------------
	initial
		forever #2.5 clk_sys = ~clk_sys;

	// hang guard
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			n_fail++;
			test_done();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// one-hot enable to array operation code
	function automatic logic [1:0] op_of(input logic [7:0] c);
		if (c[fps_pkg::BIT_NORM_PGM])
			return fps_pkg::OP_PGM;
		if (c[fps_pkg::BIT_SECT_ERS])
			return fps_pkg::OP_SERS;
		if (c[fps_pkg::BIT_OPT_PGM])
			return fps_pkg::OP_OPGM;
		return fps_pkg::OP_WHOLE_CHIP_ERASE_ENABLE;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] ad, input logic [31:0] wd);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] ad, output logic [31:0] q);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	// keys in order, or with key1 and key2 swapped
	task automatic keys(input logic [31:0] kv, input logic sw);
		int j;
		for (int i = 0; i < 4; i++)
		begin
			j = (sw && (i == 1 || i == 2)) ? 3 - i : i;
			wr(fps_pkg::OFS_KEY0 + 16'(j), {24'h0, kv[31-8*j -: 8]});
		end
	endtask

	task automatic start(input logic [7:0] c, input logic h, input logic [31:0] ad,
		input logic [31:0] dd, input logic [31:0] kv, input logic sw);
		wr(fps_pkg::OFS_ACC, {24'h0, h, 7'h03});
		wr(fps_pkg::OFS_DATA, dd);
		wr(fps_pkg::OFS_ADDR, ad);
		keys(kv, sw);
		wr(fps_pkg::OFS_OPCTL, {24'h0, c});
	endtask

	task automatic wait_go();
		seen = 1'b0;
		repeat (10)
		begin
			@(posedge clk_sys);
			#1;
			if (arr_go === 1'b1)
			begin
				seen = 1'b1;
				break;
			end
		end
	endtask

	// refused start: no pulse, start bit cleared
	task automatic nogo();
		wait_go();
		chk({31'h0, seen}, 32'h0);
		rd(fps_pkg::OFS_OPCTL, rv);
		chk({31'h0, rv[fps_pkg::BIT_START]}, 32'h0);
	endtask

	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		sh[0] = '1;
		sh[1] = '1;
		r = 32'h51;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(fps_pkg::OFS_ADDR, rv);
		chk(rv, fps_pkg::RST_WORD);
		rd(fps_pkg::OFS_DATA, rv);
		chk(rv, fps_pkg::RST_WORD);
		rd(fps_pkg::OFS_OPCTL, rv);
		chk(rv, {24'h0, fps_pkg::RST_OPCTL});
		rd(fps_pkg::OFS_ERR, rv);
		chk(rv, {24'h0, fps_pkg::RST_ERR});
		rd(fps_pkg::OFS_KEY0, rv);
		chk(rv, {24'h0, fps_pkg::RST_KEY});
		// every operation kind, random address, data, hold and speed
		for (int i = 0; i < 6; i++)
		begin
			r = lfsr(r);
			d = r;
			r = lfsr(r);
			k = i % 4;
			a = r & 32'h0003_fffc;
			if (k == 1)
				a[8:0] = 9'h0;
			if (k == 2)
				a = r[0] ? fps_pkg::OPT_PROT_ADR : fps_pkg::OPT_SMART_ADR;
			early <= r[6];
			ng = n_go;
			start(ctl[k], r[5], a, d, 32'h5aa5_5aa5, 1'b0);
			wait_go();
			chk({31'h0, seen}, 32'h1);
			@(posedge clk_sys);
			#1 chk({31'h0, cpu_hold}, {31'h0, r[5]});
			wr(fps_pkg::OFS_ADDR, a ^ 32'h4);
			// polling software sees start still set while running
			rd(fps_pkg::OFS_OPCTL, rv);
			chk({31'h0, rv[fps_pkg::BIT_START]}, 32'h1);
			for (int t = 0; t < 60 && arr_busy !== 1'b0; t++)
			begin
				@(posedge clk_sys);
				#1;
			end
			chk({31'h0, arr_busy}, 32'h0);
			chk(32'(n_go), 32'(ng + 1));
			chk({30'h0, last_op}, {30'h0, op_of(ctl[k])});
			chk(last_addr, a);
			if (k == 0 || k == 2)
				chk(last_wdata, d);
			rd(fps_pkg::OFS_OPCTL, rv);
			chk({31'h0, rv[fps_pkg::BIT_START]}, 32'h0);
			rd(fps_pkg::OFS_ADDR, rv);
			chk(rv, a);
			// option shadows: programmed by and, chip erase sets all ones
			if (k == 2)
				sh[a[2]] = sh[a[2]] & d;
			if (k == 3)
			begin
				sh[0] = '1;
				sh[1] = '1;
			end
			if (k >= 2)
			begin
				rd(fps_pkg::OFS_SOPT_RD, rv);
				chk(rv, sh[0]);
				rd(fps_pkg::OFS_POPT_RD, rv);
				chk(rv, sh[1]);
			end
		end
		wr(fps_pkg::OFS_OPCTL, 32'h88);
		nogo();
		start(8'h88, 1'b0, 32'h100, 32'h1, 32'h5aa5_5aa5, 1'b1);
		nogo();
		// a clean rewrite after a bad order must unlock again
		start(8'h88, 1'b0, 32'h104, 32'h1, 32'h5aa5_5aa5, 1'b0);
		wait_go();
		chk({31'h0, seen}, 32'h1);
		repeat (30) @(posedge clk_sys);
		#1 chk(last_addr, 32'h104);
		start(8'h88, 1'b0, 32'h100, 32'h1, 32'h5aa5_5a00, 1'b0);
		nogo();
		start(8'h8a, 1'b0, 32'h100, 32'h1, 32'h5aa5_5aa5, 1'b0);
		nogo();
		rd(fps_pkg::OFS_ERR, rv);
		chk(rv, 32'h81);
		wr(fps_pkg::OFS_ERR, 32'h0);
		rd(fps_pkg::OFS_ERR, rv);
		chk(rv, 32'h01);
		rd(fps_pkg::OFS_OPCTL, rv);
		chk(rv, 32'h0);
		keys(32'h5aa5_5aa5, 1'b0);
		wr(fps_pkg::OFS_ERR, 32'h0);
		wr(fps_pkg::OFS_OPCTL, 32'h88);
		nogo();
		@(posedge clk_sys);
		programming_mode_pin <= 1'b1;
		start(8'h82, 1'b0, 32'h200, 32'h0, 32'h5aa5_5aa5, 1'b0);
		nogo();
		chk({31'h0, sys_reset_hold}, 32'h1);
		@(posedge clk_sys);
		programming_mode_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk({31'h0, sys_reset_hold}, 32'h0);
		test_done();
	end
endmodule // tb_fps_sequencer
